// File: cpe_top.sv
// Cache parity generation, checking and memory system error register
`timescale 1ns/1ps
`default_nettype none
module cpe_top (
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire cpe_pkg::cpe_lookup_t           lookup,
  input  wire cpe_pkg::cpe_busrd_t            busrd,
  input  wire cpe_pkg::cpe_ipr_t              ipr,
  input  wire logic [31:0]                    io_addr,
  input  wire logic [31:0]                    fill_data,
  input  wire logic [cpe_pkg::CPE_TAG_W-1:0]  fill_tag,
  output logic [3:0]                          fill_data_par,
  output logic                                fill_tag_par,
  output logic [31:0]                         ipr_rdata,
  output logic                                cache_enable,
  output logic                                cache_diag,
  output logic                                wrong_parity,
  output logic                                io_diag_hit,
  output logic                                flush_req,
  output logic                                prefetch_halt,
  output logic                                mchk_req,
  output logic [7:0]                          mchk_vector,
  output logic                                err_intr_req
);

  // Byte parity: odd-numbered bytes odd, even-numbered bytes even
  function automatic logic [3:0] gen_data_par(input logic [31:0] d);
    logic [3:0] p;
    p = '0;
    for (int i = 0; i < 4; i++) begin
      p[i] = ^d[8*i +: 8] ^ i[0];
    end
    return p;
  endfunction

  // Tag stored with odd parity, valid bit excluded
  function automatic logic gen_tag_par(input logic [cpe_pkg::CPE_TAG_W-1:0] t);
    return ~(^t);
  endfunction

  logic [6:0] mse_q, mse_d;
  logic [3:0] cc_q, cc_d;
  logic       flush_q, flush_d;
  logic       halt_q, halt_d;
  logic       mchk_q, mchk_d;
  logic       intr_q, intr_d;
  logic [3:0] fdp_q, fdp_d;
  logic       ftp_q, ftp_d;
  logic [31:0] rd_q, rd_d;
  logic       diag_q, diag_d;

  logic       chk_en;
  logic       tag_err;
  logic       data_err;
  logic       log_tag;
  logic       log_data;
  logic       is_rd;
  logic       is_wr;
  logic       bp_seen;
  logic       bp_mchk;
  logic       cp_mchk;
  logic       mse_wr;
  logic       cc_wr;
  logic [3:0] rd_par;

  // Checking only on valid hits while cache is enabled
  always_comb begin
    chk_en   = lookup.valid && lookup.hit && lookup.entry_valid && cc_q[cpe_pkg::CPE_CC_ENA];
    is_rd    = (lookup.kind == cpe_pkg::CPE_REF_DREAD) || (lookup.kind == cpe_pkg::CPE_REF_IREAD);
    is_wr    = (lookup.kind == cpe_pkg::CPE_REF_CPUWR) || (lookup.kind == cpe_pkg::CPE_REF_DMAWR);
    // Wrong-parity diagnostic inverts only the stored data parity
    rd_par   = lookup.data_par ^ {4{cc_q[cpe_pkg::CPE_CC_WWP]}};
    tag_err  = chk_en && (is_rd || is_wr) && (gen_tag_par(lookup.tag) != lookup.tag_par);
    data_err = chk_en && is_rd && (gen_data_par(lookup.data) != rd_par);
    log_tag  = tag_err;
    log_data = data_err && !tag_err;
    cp_mchk  = (tag_err || data_err) && (lookup.kind == cpe_pkg::CPE_REF_DREAD);
    bp_seen  = busrd.valid && busrd.par_err && busrd.rdy && !busrd.err &&
               ((busrd.kind == cpe_pkg::CPE_REF_DREAD) ||
                (busrd.kind == cpe_pkg::CPE_REF_IREAD));
    bp_mchk  = bp_seen && (busrd.kind == cpe_pkg::CPE_REF_DREAD);
    mse_wr   = ipr.valid && ipr.write && (ipr.num == cpe_pkg::CPE_IPR_MSE);
    cc_wr    = ipr.valid && ipr.write && (ipr.num == cpe_pkg::CPE_IPR_CCTL);
  end

  // Error register: any write clears, but a same-cycle error still sets
  always_comb begin
    mse_d = mse_wr ? cpe_pkg::CPE_MSE_RST : mse_q;
    if (log_tag) begin
      mse_d[cpe_pkg::CPE_BIT_TAG] = 1'b1;
    end
    if (log_data) begin
      mse_d[cpe_pkg::CPE_BIT_DATA] = 1'b1;
    end
    if (cp_mchk) begin
      mse_d[cpe_pkg::CPE_BIT_MCCP] = 1'b1;
    end
    if (bp_mchk) begin
      mse_d[cpe_pkg::CPE_BIT_MCBP] = 1'b1;
    end
    if (bp_seen) begin
      mse_d[cpe_pkg::CPE_BIT_BP] = 1'b1;
    end
  end

  // Cache control and error actions
  always_comb begin
    cc_d    = cc_q;
    flush_d = 1'b0;
    halt_d  = 1'b0;
    mchk_d  = 1'b0;
    intr_d  = 1'b0;
    if (cc_wr) begin
      cc_d = {ipr.wdata[cpe_pkg::CPE_CC_WWP], ipr.wdata[cpe_pkg::CPE_CC_ENA], 1'b0,
              ipr.wdata[cpe_pkg::CPE_CC_DIA]};
      flush_d = ipr.wdata[cpe_pkg::CPE_CC_FLU];
    end
    if (tag_err || data_err) begin
      case (lookup.kind)
        cpe_pkg::CPE_REF_DREAD: begin
          flush_d = 1'b1;
          cc_d    = cpe_pkg::CPE_CC_RST;
          mchk_d  = 1'b1;
        end
        cpe_pkg::CPE_REF_IREAD: begin
          flush_d = flush_d || !cc_q[cpe_pkg::CPE_CC_DIA];
          halt_d  = 1'b1;
          intr_d  = 1'b1;
        end
        cpe_pkg::CPE_REF_CPUWR: begin
          flush_d = flush_d || !cc_q[cpe_pkg::CPE_CC_DIA];
          intr_d  = 1'b1;
        end
        cpe_pkg::CPE_REF_DMAWR: begin
          intr_d  = 1'b1;
        end
        default: begin
          intr_d  = 1'b0;
        end
      endcase
    end
    if (bp_mchk) begin
      mchk_d = 1'b1;
    end else if (bp_seen) begin
      intr_d = 1'b1;
    end
  end

  // Register readback, fill parity and diagnostic window decode
  always_comb begin
    rd_d = rd_q;
    if (ipr.valid && !ipr.write) begin
      case (ipr.num)
        cpe_pkg::CPE_IPR_MSE:  rd_d = {25'h0, mse_q} & cpe_pkg::CPE_MSE_MASK;
        cpe_pkg::CPE_IPR_CCTL: rd_d = ({28'h0, cc_q} & cpe_pkg::CPE_CC_RD_MASK) |
                                      cpe_pkg::CPE_CC_ONE;
        default:               rd_d = 32'h0000_0000;
      endcase
    end
    fdp_d  = gen_data_par(fill_data);
    ftp_d  = gen_tag_par(fill_tag);
    diag_d = cc_q[cpe_pkg::CPE_CC_DIA] && (io_addr >= cpe_pkg::CPE_DIAG_LO) &&
             (io_addr <= cpe_pkg::CPE_DIAG_HI);
  end

  // State registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mse_q   <= cpe_pkg::CPE_MSE_RST;
      cc_q    <= cpe_pkg::CPE_CC_RST;
      flush_q <= 1'b0;
      halt_q  <= 1'b0;
      mchk_q  <= 1'b0;
      intr_q  <= 1'b0;
      fdp_q   <= 4'h0;
      ftp_q   <= 1'b0;
      rd_q    <= 32'h0000_0000;
      diag_q  <= 1'b0;
    end else begin
      mse_q   <= mse_d;
      cc_q    <= cc_d;
      flush_q <= flush_d;
      halt_q  <= halt_d;
      mchk_q  <= mchk_d;
      intr_q  <= intr_d;
      fdp_q   <= fdp_d;
      ftp_q   <= ftp_d;
      rd_q    <= rd_d;
      diag_q  <= diag_d;
    end
  end

  // Outputs from flops, vector constant; machine check pulses with the error bit update
  assign ipr_rdata     = rd_q;
  assign cache_enable  = cc_q[cpe_pkg::CPE_CC_ENA];
  assign cache_diag    = cc_q[cpe_pkg::CPE_CC_DIA];
  assign wrong_parity  = cc_q[cpe_pkg::CPE_CC_WWP];
  assign io_diag_hit   = diag_q;
  assign flush_req     = flush_q;
  assign prefetch_halt = halt_q;
  assign mchk_req      = mchk_q;
  assign mchk_vector   = cpe_pkg::CPE_MCHK_VECTOR;
  assign err_intr_req  = intr_q;
  assign fill_data_par = fdp_q;
  assign fill_tag_par  = ftp_q;

endmodule
`default_nettype wire

// File: cpe_pkg.sv
// Package for the cache parity error reporting block: offsets, fields, types
// Behaviour
// - Error register bits 31:7, 3:2 read zero
// - Bus parity flag on normally terminated reads
// - Bus parity machine check on demand reads
// - Cache parity machine check on demand read hits
// - Data error bit set only without a tag error
// - Simultaneous tag and data logs tag only
// - Sticky bits clear on any error register write
// - New errors only add set bits
// - Parity per data byte and tag, not valid
// - Odd bytes odd, even bytes even, tag odd
// - Invalid entries never signal parity errors
// - Read hits check all; write hits tag only
// - Demand data read error flushes, disables, aborts
// - Instruction request error flushes unless diagnostic, halts prefetch
// - CPU write tag error flushes unless diagnostic
// - DMA write tag error records bit, interrupts, no flush
// - Fatal errors trap vector four, others interrupt
// - Flush bit clears valid bits, reads zero
// - Cache disabled: all miss, no parity checks
// - Diagnostic bit maps cache into I/O space
package cpe_pkg;
  localparam logic [7:0]  CPE_IPR_MSE     = 8'h27;  // Error register number
  localparam logic [7:0]  CPE_IPR_CCTL    = 8'h25;  // Cache control register number
  localparam logic [7:0]  CPE_MCHK_VECTOR = 8'h04;
  localparam int          CPE_BIT_TAG     = 0;
  localparam int          CPE_BIT_DATA    = 1;
  localparam int          CPE_BIT_MCCP    = 4;
  localparam int          CPE_BIT_MCBP    = 5;
  localparam int          CPE_BIT_BP      = 6;
  localparam int          CPE_CC_DIA      = 0;
  localparam int          CPE_CC_FLU      = 1;
  localparam int          CPE_CC_ENA      = 2;
  localparam int          CPE_CC_WWP      = 3;
  localparam logic [31:0] CPE_MSE_MASK    = 32'h0000_0073;
  localparam logic [31:0] CPE_CC_RD_MASK  = 32'h0000_000D;
  localparam logic [31:0] CPE_CC_ONE      = 32'h0000_0010;
  localparam logic [6:0]  CPE_MSE_RST     = 7'h00;
  localparam logic [3:0]  CPE_CC_RST      = 4'h0;
  localparam int          CPE_TAG_W       = 19;
  localparam logic [31:0] CPE_DIAG_LO     = 32'h2015_0000;
  localparam logic [31:0] CPE_DIAG_HI     = 32'h2015_0FFF;

  typedef enum logic [2:0] {
    CPE_REF_NONE   = 3'b000,
    CPE_REF_DREAD  = 3'b001,  // Demand data-stream read
    CPE_REF_IREAD  = 3'b010,  // Request instruction-stream read
    CPE_REF_CPUWR  = 3'b011,  // Masked or unmasked CPU write
    CPE_REF_DMAWR  = 3'b100
  } cpe_ref_t;

  // One cache lookup presented by the core for checking
  typedef struct packed {
    logic                 valid;
    cpe_ref_t             kind;
    logic                 hit;
    logic                 entry_valid;
    logic [CPE_TAG_W-1:0] tag;
    logic                 tag_par;
    logic [31:0]          data;
    logic [3:0]           data_par;
  } cpe_lookup_t;

  // One terminated bus read cycle
  typedef struct packed {
    logic     valid;
    cpe_ref_t kind;
    logic     rdy;
    logic     err;
    logic     par_err;
  } cpe_busrd_t;

  // Processor register access
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  num;
    logic [31:0] wdata;
  } cpe_ipr_t;
endpackage

// File: cpe_monitor.sv
// Checker of error reporting timing at the top ports
`timescale 1ns/1ps
`default_nettype none
module cpe_monitor (
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire cpe_pkg::cpe_lookup_t lookup,
  input wire cpe_pkg::cpe_busrd_t  busrd,
  input wire cpe_pkg::cpe_ipr_t    ipr,
  input wire logic [31:0]          ipr_rdata,
  input wire logic                 cache_enable,
  input wire logic                 prefetch_halt,
  input wire logic                 flush_req,
  input wire logic                 mchk_req,
  input wire logic [7:0]           mchk_vector,
  input wire logic                 err_intr_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Valid hits with no bus traffic beside them, so causes stay apart
  wire lk = lookup.valid && lookup.hit && lookup.entry_valid && !busrd.valid && cache_enable;
  wire tag_bad = ~^{lookup.tag, lookup.tag_par};
  wire bp = busrd.valid && busrd.rdy && !busrd.err && busrd.par_err;
  wire quiet = lookup.valid && !busrd.valid;
  AST_VECTOR: assert property (mchk_req |-> mchk_vector == 8'h04)
    else $error("machine check vector wrong");
  AST_BUS_MCHK: assert property (bp && busrd.kind == cpe_pkg::CPE_REF_DREAD |=> mchk_req)
    else $error("bus parity on demand read gave no machine check");
  AST_BUS_ABORTED: assert property (busrd.valid && busrd.err && !lookup.valid
    |=> !mchk_req && !err_intr_req) else $error("aborted bus read reported");
  AST_DREAD_ABORT: assert property (lk && tag_bad && lookup.kind == cpe_pkg::CPE_REF_DREAD
    |=> mchk_req && flush_req && !cache_enable) else $error("demand read error not aborted");
  AST_IREAD_HALT: assert property (lk && tag_bad && lookup.kind == cpe_pkg::CPE_REF_IREAD
    |=> prefetch_halt && !mchk_req && cache_enable) else $error("request read error mishandled");
  AST_DMA_INTR: assert property (lk && tag_bad && lookup.kind == cpe_pkg::CPE_REF_DMAWR
    |=> err_intr_req && !mchk_req && !flush_req) else $error("dma write error mishandled");
  AST_DISABLED: assert property (quiet && !cache_enable |=> !mchk_req && !err_intr_req)
    else $error("disabled cache reported an error");
  AST_INVALID: assert property (quiet && !lookup.entry_valid |=> !mchk_req && !err_intr_req)
    else $error("invalid entry reported an error");
  AST_RSVD: assert property (ipr.valid && !ipr.write && ipr.num == cpe_pkg::CPE_IPR_MSE
    |=> (ipr_rdata & 32'hFFFF_FF8C) == 32'h0) else $error("reserved error bits not zero");
endmodule
bind cpe_top cpe_monitor i_mon (.clk(clk), .rst_b(rst_b), .lookup(lookup), .busrd(busrd),
  .ipr(ipr), .ipr_rdata(ipr_rdata), .cache_enable(cache_enable), .prefetch_halt(prefetch_halt),
  .flush_req(flush_req), .mchk_req(mchk_req), .mchk_vector(mchk_vector),
  .err_intr_req(err_intr_req));
`default_nettype wire

// File: cpe_core_model.sv
// Core side model: one cache entry presented as lookups with stored parity
`timescale 1ns/1ps
`default_nettype none
module cpe_core_model (
  input  wire logic               go,
  input  wire cpe_pkg::cpe_ref_t  kind,
  input  wire logic [2:0]         flags,  // Entry valid, tag bad, data bad
  output var cpe_pkg::cpe_lookup_t lookup
);
  localparam logic [18:0] TAG = 19'h2A5C3;
  localparam logic [31:0] DAT = 32'h1234_5679;
  // Idle lines show inverted values so stale data never looks current
  always_comb begin
    lookup = '0;
    lookup.valid = go;
    lookup.kind = go ? kind : cpe_pkg::CPE_REF_NONE;
    lookup.hit = go;
    lookup.entry_valid = flags[2];
    lookup.tag = go ? TAG : ~TAG;
    lookup.data = go ? DAT : ~DAT;
    lookup.tag_par = ~^TAG ^ flags[1];
    lookup.data_par = {~^DAT[31:24], ^DAT[23:16], ~^DAT[15:8], ^DAT[7:0]} ^ {4{flags[0]}};
  end
endmodule
`default_nettype wire

// File: cache_parity_error_reporting_bench.sv
// Register level testbench for the cache parity error block
`timescale 1ns/1ps
`default_nettype none
module cache_parity_error_reporting_bench;
  localparam logic [7:0] MSE = cpe_pkg::CPE_IPR_MSE;
  localparam logic [7:0] CCT = cpe_pkg::CPE_IPR_CCTL;
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 go = 1'b0;
  cpe_pkg::cpe_ref_t    kind = cpe_pkg::CPE_REF_NONE;
  logic [2:0]           flags = 3'h0;
  cpe_pkg::cpe_lookup_t lookup;
  cpe_pkg::cpe_busrd_t  busrd = '0;
  cpe_pkg::cpe_ipr_t    ipr = '0;
  logic [31:0]          fill_data = 32'h0;
  logic [18:0]          fill_tag = 19'h0;
  logic [3:0]           fill_data_par;
  logic                 fill_tag_par;
  logic [31:0]          ipr_rdata;
  logic [31:0]          io_addr = 32'h0;
  logic                 flush_req;
  logic                 io_diag_hit;
  int                   miscompares = 0;
  int                   tests_run = 0;
  cpe_core_model i_core (.go(go), .kind(kind), .flags(flags), .lookup(lookup));
  cpe_top i_dut (.clk(clk), .rst_b(rst_b), .lookup(lookup), .busrd(busrd), .ipr(ipr),
    .io_addr(io_addr), .fill_data(fill_data), .fill_tag(fill_tag),
    .fill_data_par(fill_data_par), .fill_tag_par(fill_tag_par), .ipr_rdata(ipr_rdata),
    .cache_enable(), .cache_diag(), .wrong_parity(), .io_diag_hit(io_diag_hit),
    .flush_req(flush_req),
    .prefetch_halt(), .mchk_req(), .mchk_vector(), .err_intr_req());
  always #2.5 clk = ~clk;
  task automatic final_report;
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register access: one cycle of valid, answer one edge later
  task automatic ipr_wr(input logic [7:0] num, input logic [31:0] d);
    @(negedge clk) ipr <= '{1'b1, 1'b1, num, d};
    @(negedge clk) ipr <= '0;
  endtask
  task automatic ipr_rd(input logic [7:0] num, input logic [31:0] exp);
    @(negedge clk) ipr <= '{1'b1, 1'b0, num, 32'h0};
    @(negedge clk) ipr <= '0;
    chk(ipr_rdata, exp);
  endtask
  task automatic look(input cpe_pkg::cpe_ref_t k, input logic [2:0] f, input logic [31:0] exp);
    @(negedge clk) begin
      go <= 1'b1;
      kind <= k;
      flags <= f;
    end
    @(negedge clk) go <= 1'b0;
    ipr_rd(MSE, exp);
  endtask
  task automatic bus(input cpe_pkg::cpe_ref_t k, input logic e, input logic [31:0] exp);
    @(negedge clk) busrd <= '{1'b1, k, 1'b1, e, 1'b1};
    @(negedge clk) busrd <= '0;
    ipr_rd(MSE, exp);
  endtask
  // Watchdog in case the sequence hangs
  initial begin
    #100us;
    miscompares++;
    final_report;
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) rst_b <= 1'b1;
    ipr_rd(MSE, 32'h0);
    ipr_rd(CCT, 32'h10);
    ipr_wr(CCT, 32'h6);
    chk({31'h0, flush_req}, 32'h1);
    ipr_rd(CCT, 32'h14);
    fill_data <= 32'h0102_0307;
    fill_tag <= 19'h3;
    look(cpe_pkg::CPE_REF_DREAD, 3'b100, 32'h0);
    chk({27'h0, fill_tag_par, fill_data_par}, 32'h17);
    look(cpe_pkg::CPE_REF_IREAD, 3'b101, 32'h2);
    look(cpe_pkg::CPE_REF_IREAD, 3'b011, 32'h2);
    ipr_wr(MSE, 32'hFFFF_FFFF);
    ipr_rd(MSE, 32'h0);
    look(cpe_pkg::CPE_REF_IREAD, 3'b111, 32'h1);
    look(cpe_pkg::CPE_REF_IREAD, 3'b101, 32'h3);
    ipr_wr(MSE, 32'h0);
    look(cpe_pkg::CPE_REF_CPUWR, 3'b101, 32'h0);
    look(cpe_pkg::CPE_REF_CPUWR, 3'b110, 32'h1);
    ipr_wr(MSE, 32'h0);
    look(cpe_pkg::CPE_REF_DMAWR, 3'b110, 32'h1);
    ipr_rd(CCT, 32'h14);
    ipr_wr(MSE, 32'h0);
    ipr_wr(CCT, 32'hC);
    look(cpe_pkg::CPE_REF_IREAD, 3'b100, 32'h2);
    ipr_wr(CCT, 32'h4);
    ipr_wr(MSE, 32'h0);
    bus(cpe_pkg::CPE_REF_IREAD, 1'b1, 32'h0);
    bus(cpe_pkg::CPE_REF_IREAD, 1'b0, 32'h40);
    bus(cpe_pkg::CPE_REF_DREAD, 1'b0, 32'h60);
    look(cpe_pkg::CPE_REF_DREAD, 3'b110, 32'h71);
    ipr_rd(CCT, 32'h10);
    look(cpe_pkg::CPE_REF_DREAD, 3'b101, 32'h71);
    ipr_wr(CCT, 32'h1);
    io_addr <= 32'h2015_0800;
    ipr_rd(CCT, 32'h11);
    chk({31'h0, io_diag_hit}, 32'h1);
    io_addr <= 32'h2015_1000;
    ipr_rd(CCT, 32'h11);
    chk({31'h0, io_diag_hit}, 32'h0);
    final_report;
  end
endmodule
`default_nettype wire
